//--- tb/fser_flash_model.sv
// Behavioural flash device that answers the host controller's status bus cycles.
`timescale 1ns/1ps
`include "fser_defines.svh"
module fser_flash_model (
  input  wire logic [`FSER_AW-1:0] a,
  input  wire logic [`FSER_DW-1:0] dq_w,
  input  wire logic                dq_oe_n,
  input  wire logic                ce_n,
  input  wire logic                oe_n,
  input  wire logic                we_n,
  input  wire logic [2:0]          mode,
  input  wire logic                load,
  input  wire logic [`FSER_DW-1:0] arr,
  output logic [`FSER_DW-1:0]      dq_r,
  output logic                     ry
);
  // ==========================================================================
  // State: 0 standby, 1 program, 2 erase, 3 program error, 4 erase error, 5 abort,
  // 6 erase suspended, 7 erase with its start window still open.
  logic [2:0]          st;
  logic                gt;
  logic                tg;
  logic                srd;
  logic [1:0]          unl;
  logic [7:0]          sr;
  logic [`FSER_DW-1:0] word;
  logic [`FSER_DW-1:0] last;
  initial begin
    st = 3'h0; gt = 1'b0; tg = 1'b0; srd = 1'b0; unl = 2'h0; last = 16'h0000;
  end
  always @(posedge load) st = mode;
  assign ry = (st == 3'h0 || st == 3'h6);
  always_comb begin
    case (st)
      3'h3:    sr = 8'h90;
      3'h4:    sr = 8'hA0;
      3'h5:    sr = 8'h98;
      default: sr = 8'h00;
    endcase
  end
  always_comb begin
    word = arr;
    if (st != 3'h0) begin
      word[7] = (st == 3'h6) ? 1'b1 : (st == 3'h2 || st == 3'h4 || st == 3'h7) ? 1'b0 : ~arr[7];
      word[6] = gt;
      word[5] = (st == 3'h3 || st == 3'h4);
      word[4] = ~gt;
      word[3] = (st == 3'h2 || st == 3'h4);
      word[2] = tg;
      word[1] = (st == 3'h5);
      word[0] = gt;
    end
    if (srd) word = {8'h00, sr};
  end
  // A released bus shows the inverse of the last word so stale data never passes.
  assign dq_r = (!ce_n && !oe_n) ? word : ~last;
  always @(posedge oe_n) begin
    last = word;
    srd = 1'b0;
    if (st != 3'h0 && st != 3'h6) gt = ~gt;
    if (st == 3'h2 || st == 3'h3 || st == 3'h4 || st >= 3'h6) tg = ~tg;
  end
  always @(posedge we_n) begin
    if (!dq_oe_n && a == `FSER_A_UNLK1 && dq_w == `FSER_CMD_SRRD) srd = 1'b1;
    else if (!dq_oe_n && a == `FSER_A_UNLK1 && dq_w == `FSER_CMD_SRCLR) st = 3'h0;
    else if (!dq_oe_n && a == `FSER_A_UNLK1 && dq_w == `FSER_CMD_RESET) begin
      if (st != 3'h5 || unl == 2'h2) st = 3'h0;
    end
    if (!dq_oe_n && a == `FSER_A_UNLK1 && dq_w == `FSER_CMD_UNLK1) unl = 2'h1;
    else if (!dq_oe_n && a == `FSER_A_UNLK2 && dq_w == `FSER_CMD_UNLK2 && unl == 2'h1) unl = 2'h2;
    else unl = 2'h0;
  end
endmodule

//--- tb/tb_fser_host.sv
// Self-checking bench for the host controller against the flash model.
`timescale 1ns/1ps
`include "fser_defines.svh"
module tb_fser_host;
  import fser_pkg::*;
  // ==========================================================================
  // Signals.
  logic                MCLK = 1'b0;
  logic                RST = 1'b1;
  logic [1:0]          av_a = 2'h0;
  logic                av_r = 1'b0;
  logic                av_w = 1'b0;
  logic [31:0]         av_wd = 32'h0;
  logic [31:0]         av_rd_d;
  logic                av_wait;
  logic [`FSER_AW-1:0] fa;
  logic [`FSER_DW-1:0] dq_i;
  logic [`FSER_DW-1:0] dq_o;
  logic                dq_oe_n, ce_n, oe_n, we_n, ry;
  logic [2:0]          mode = 3'h0;
  logic                load = 1'b0;
  logic [`FSER_DW-1:0] arr = 16'h0000;
  logic [63:0]         exp_q[$];
  logic [63:0]         e;
  int                  bad_count = 0;
  int                  cmp_count = 0;
  integer              seed = 32'h95B5E0FD;
  always #5 MCLK = ~MCLK;
  fser_host dut_u (.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(av_a), .AVS_READ(av_r),
    .AVS_WRITE(av_w), .AVS_WRITEDATA(av_wd), .AVS_READDATA(av_rd_d),
    .AVS_WAITREQUEST(av_wait), .FL_A(fa), .FL_DQ_I(dq_i), .FL_DQ_O(dq_o),
    .FL_DQ_OE_N(dq_oe_n), .FL_CE_N(ce_n), .FL_OE_N(oe_n), .FL_WE_N(we_n), .FL_READY_BUSY_PIN(ry));
  fser_flash_model flash_u (.a(fa), .dq_w(dq_o), .dq_oe_n(dq_oe_n), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .mode(mode), .load(load), .arr(arr), .dq_r(dq_i), .ry(ry));
  // ==========================================================================
  // Tasks.
  task give_verdict();
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task cmp_rd(input logic [31:0] got, input logic [63:0] x);
    cmp_count++;
    if ((got & x[31:0]) !== x[63:32]) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got & x[31:0], x[63:32]);
    end
  endtask
  task av_xfer(input logic [1:0] a, input logic wr, input logic [31:0] wd);
    int n;
    begin
      @(posedge MCLK);
      av_a <= a; av_r <= ~wr; av_w <= wr; av_wd <= wd;
      n = 0;
      do begin
        @(posedge MCLK);
        n++;
        if (n > 20) begin bad_count++; give_verdict(); end
      end while (av_wait !== 1'b0);
      av_r <= 1'b0; av_w <= 1'b0;
    end
  endtask
  task av_rd(input logic [1:0] a, input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back({x, m});
    av_xfer(a, 1'b0, 32'h0);
  endtask
  task run_op(input logic [31:0] ctl);
    int n;
    begin
      av_xfer(`FSER_REG_CTRL, 1'b1, ctl);
      n = 0;
      do begin
        av_rd(`FSER_REG_STAT, 32'h0, 32'h0);
        n++;
        if (n > 1500) begin bad_count++; give_verdict(); end
      end while (av_rd_d[0] !== 1'b0);
    end
  endtask
  task set_mode(input logic [2:0] m);
    @(posedge MCLK);
    mode <= m; load <= 1'b1;
    @(posedge MCLK);
    load <= 1'b0;
  endtask
  function automatic logic [31:0] st_exp(input logic [2:0] m, input fser_res_t r);
    st_exp = {11'h0, m == 3'h2 || m == 3'h4, m == 3'h5, m == 3'h3 || m == 3'h4,
              (m >= 3'h2 && m <= 3'h4) || m >= 3'h6, m != 3'h0 && m != 3'h6, 11'h0,
              m == 3'h0 || m == 3'h6, r, 1'b0};
  endfunction
  always @(posedge MCLK) begin
    if (av_r === 1'b1 && av_wait === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      cmp_rd(av_rd_d, e);
    end
  end
  // ==========================================================================
  // Main sequence: poll every device state, then read and clear each error.
  logic [15:0] w;
  fser_res_t   res [8] = '{RES_DONE, RES_BUSY, RES_BUSY, RES_EMBERR, RES_EMBERR, RES_ABORT,
                           RES_DONE, RES_BUSY};
  initial begin
    repeat (3) @(posedge MCLK);
    RST <= 1'b0;
    av_rd(`FSER_REG_STAT, 32'h0, 32'h0000_000F);
    for (int m = 0; m < 8; m++) begin
      @(posedge MCLK);
      arr <= 16'($random(seed));
      set_mode(m[2:0]);
      av_xfer(`FSER_REG_ADDR, 1'b1, $random(seed) & 32'h03FF_FFFF);
      run_op(32'h1);
      av_rd(`FSER_REG_STAT, st_exp(m[2:0], res[m]),
            m == 0 ? 32'h1F : 32'h001F_001F);
      w = {arr[15:8], (m == 1 || m == 3 || m == 5) ? ~arr[7] : m == 6, 1'b0,
           m == 3 || m == 4, 1'b0, m == 2 || m == 4, 1'b0, m == 5, 1'b0};
      if (m == 0) w = arr;
      av_rd(`FSER_REG_DATA, {w, w} & 32'hFFAA_FFAA, 32'hFFAA_FFAA);
      if (m >= 3 && m <= 5) begin
        run_op(32'h2);
        av_rd(`FSER_REG_STAT, {16'h0, m == 3 ? 8'h90 : m == 4 ? 8'hA0 : 8'h98, 8'h0},
              32'h0000_FE00);
        if (m == 5) begin
          run_op(32'h4);
          av_rd(`FSER_REG_STAT, {28'h0, RES_TIMEOUT, 1'b0}, 32'h1F);
        end
        run_op(m == 3 ? 32'h3 : m == 4 ? 32'h4 : 32'h5);
        av_rd(`FSER_REG_STAT, {27'h0, 1'b1, RES_CLEARED, 1'b0}, 32'h1F);
      end else begin
        set_mode(3'h0);
      end
    end
    for (int m = 3; m < 6; m += 2) begin
      set_mode(m[2:0]);
      run_op(32'h101);
      av_rd(`FSER_REG_STAT, {27'h0, 1'b1, RES_CLEARED, 1'b0}, 32'h1F);
    end
    give_verdict();
  end
endmodule

//--- verilog/fser_cyc_if.sv
// One flash bus cycle request and its answer between controller and pin engine.
`timescale 1ns/1ps
`include "fser_defines.svh"
interface fser_cyc_if;
  logic                req;
  logic                we;
  logic [`FSER_AW-1:0] addr;
  logic [`FSER_DW-1:0] wdata;
  logic                done;
  logic [`FSER_DW-1:0] rdata;
  logic                ry;
  modport ctl (output req, output we, output addr, output wdata,
               input done, input rdata, input ry);
  modport phy (input req, input we, input addr, input wdata,
               output done, output rdata, output ry);
endinterface

//--- verilog/fser_defines.svh
// Constants for the flash status error reporter host controller.
`ifndef FSER_DEFINES_SVH
`define FSER_DEFINES_SVH
`define FSER_AW        26
`define FSER_DW        16
`define FSER_CLK_NS    10
`define FSER_T_ACC_NS  120
`define FSER_T_WP_NS   50
`define FSER_T_REC_NS  30
`define FSER_T_RDY_NS  20000
`define FSER_ACC_CYC   ((`FSER_T_ACC_NS + `FSER_CLK_NS - 1) / `FSER_CLK_NS + 2)
`define FSER_WP_CYC    ((`FSER_T_WP_NS + `FSER_CLK_NS - 1) / `FSER_CLK_NS)
`define FSER_REC_CYC   ((`FSER_T_REC_NS + `FSER_CLK_NS - 1) / `FSER_CLK_NS)
`define FSER_RDY_CYC   (`FSER_T_RDY_NS / `FSER_CLK_NS)
`define FSER_A_UNLK1   26'h0000555
`define FSER_A_UNLK2   26'h00002AA
`define FSER_CMD_UNLK1 16'h00AA
`define FSER_CMD_UNLK2 16'h0055
`define FSER_CMD_SRRD  16'h0070
`define FSER_CMD_SRCLR 16'h0071
`define FSER_CMD_RESET 16'h00F0
`define FSER_REG_CTRL  2'h0
`define FSER_REG_ADDR  2'h1
`define FSER_REG_STAT  2'h2
`define FSER_REG_DATA  2'h3
`define FSER_CTRL_AUTO 8
`define FSER_B_GTOG    6
`define FSER_B_TLIM    5
`define FSER_B_ESTART  3
`define FSER_B_STOG    2
`define FSER_B_ABORT   1
`define FSER_POLL_MASK 16'hFFEE
`define FSER_SR_MASK   8'hFE
`endif

//--- verilog/fser_host.sv
// Host controller that polls flash status, reads it and clears flash errors.
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "fser_defines.svh"
module fser_host (
  input  wire logic                MCLK,
  input  wire logic                RST,
  input  wire logic [1:0]          AVS_ADDRESS,
  input  wire logic                AVS_READ,
  input  wire logic                AVS_WRITE,
  input  wire logic [31:0]         AVS_WRITEDATA,
  output logic [31:0]              AVS_READDATA,
  output logic                     AVS_WAITREQUEST,
  output logic [`FSER_AW-1:0]      FL_A,
  input  wire logic [`FSER_DW-1:0] FL_DQ_I,
  output logic [`FSER_DW-1:0]      FL_DQ_O,
  output logic                     FL_DQ_OE_N,
  output logic                     FL_CE_N,
  output logic                     FL_OE_N,
  output logic                     FL_WE_N,
  input  wire logic                FL_READY_BUSY_PIN
);
  import fser_pkg::*;
  typedef struct packed {
    fser_st_t            st;
    fser_op_t            op;
    logic [2:0]          step;
    logic                pend;
    logic                req;
    logic                we;
    logic [`FSER_AW-1:0] ca;
    logic [`FSER_DW-1:0] cd;
    logic [`FSER_AW-1:0] addr;
    logic                auto_clr;
    logic [`FSER_DW-1:0] p1;
    logic [`FSER_DW-1:0] p2;
    logic [7:0]          sr;
    fser_res_t           res;
    logic [4:0]          flg;
    logic [15:0]         cnt;
    logic                wrq;
    logic [31:0]         rdat;
  } fser_main_t;

  fser_main_t s;
  fser_main_t n;
  fser_res_t  cls;
  logic [4:0] flg;
  fser_cmd_t  cmd;
  fser_op_t   wop;
  fser_cyc_if cyc ();

  // ==========================================================================
  // Command sequences
  function automatic fser_cmd_t cmd_step(input fser_op_t op, input logic [2:0] step);
    fser_cmd_t c;
    c = '{last: 1'b1, a: `FSER_A_UNLK1, d: `FSER_CMD_RESET};
    unique case (op)
      OP_SRRD:  c.d = `FSER_CMD_SRRD;
      OP_SRCLR: c.d = `FSER_CMD_SRCLR;
      OP_ABRST: begin
        if (step == 3'h0) begin
          c = '{last: 1'b0, a: `FSER_A_UNLK1, d: `FSER_CMD_UNLK1};
        end else if (step == 3'h1) begin
          c = '{last: 1'b0, a: `FSER_A_UNLK2, d: `FSER_CMD_UNLK2};
        end
      end
      OP_NONE, OP_POLL, OP_RESET: c.d = `FSER_CMD_RESET;
    endcase
    return c;
  endfunction

  function automatic logic op_ok(input logic [2:0] v);
    return (v != OP_NONE) && (v <= OP_ABRST);
  endfunction

  // ==========================================================================
  // Submodules
  fser_poll_decode u_dec (
    .first  (s.p1),
    .second (s.p2),
    .cls    (cls),
    .flg    (flg)
  );

  fser_pin_engine u_pin (
    .MCLK       (MCLK),
    .RST        (RST),
    .cyc        (cyc.phy),
    .fl_a       (FL_A),
    .fl_dq_i    (FL_DQ_I),
    .fl_dq_o    (FL_DQ_O),
    .fl_dq_oe_n (FL_DQ_OE_N),
    .fl_ce_n    (FL_CE_N),
    .fl_oe_n    (FL_OE_N),
    .fl_we_n    (FL_WE_N),
    .fl_ry      (FL_READY_BUSY_PIN)
  );

  // ==========================================================================
  // Control and register slave
  always_comb begin
    n     = s;
    n.req = 1'b0;
    n.wrq = 1'b1;
    cmd   = cmd_step(s.op, s.step);
    wop   = fser_op_t'(AVS_WRITEDATA[2:0]);
    if ((AVS_READ || AVS_WRITE) && s.wrq) begin
      n.wrq = 1'b0;
      if (AVS_READ) begin
        unique case (AVS_ADDRESS)
          `FSER_REG_CTRL: n.rdat = {23'h000000, s.auto_clr, 5'h00, s.op};
          `FSER_REG_ADDR: n.rdat = {6'h00, s.addr};
          `FSER_REG_STAT: n.rdat = {11'h000, s.flg, s.sr, 3'h0, cyc.ry, s.res,
                                    s.st != S_IDLE};
          `FSER_REG_DATA: n.rdat = {s.p1, s.p2};
        endcase
      end else if (AVS_ADDRESS == `FSER_REG_ADDR) begin
        n.addr = AVS_WRITEDATA[`FSER_AW-1:0];
      end else if (AVS_ADDRESS == `FSER_REG_CTRL) begin
        n.auto_clr = AVS_WRITEDATA[`FSER_CTRL_AUTO];
        // A start while an operation runs is dropped so a sequence is never split.
        if (s.st == S_IDLE && op_ok(AVS_WRITEDATA[2:0])) begin
          n.op   = wop;
          n.step = 3'h0;
          n.res  = RES_NONE;
          n.st   = (wop == OP_POLL) ? S_RD1 : S_SEQ;
        end
      end
    end
    unique case (s.st)
      S_IDLE: n.pend = 1'b0;
      S_SEQ: begin
        if (!s.pend) begin
          n.req  = 1'b1;
          n.pend = 1'b1;
          n.we   = 1'b1;
          n.ca   = cmd.a;
          n.cd   = cmd.d;
        end else if (cyc.done) begin
          n.pend = 1'b0;
          n.step = s.step + 3'h1;
          if (cmd.last) begin
            n.cnt = 16'h0000;
            n.st  = (s.op == OP_SRRD) ? S_SRD : S_WRDY;
          end
        end
      end
      S_RD1, S_RD2, S_SRD: begin
        if (!s.pend) begin
          n.req  = 1'b1;
          n.pend = 1'b1;
          n.we   = 1'b0;
          n.ca   = s.addr;
        end else if (cyc.done) begin
          n.pend = 1'b0;
          if (s.st == S_RD1) begin
            n.p1 = cyc.rdata & `FSER_POLL_MASK;
            n.st = S_RD2;
          end else if (s.st == S_RD2) begin
            n.p2 = cyc.rdata & `FSER_POLL_MASK;
            n.st = S_EVAL;
          end else begin
            n.sr  = cyc.rdata[7:0] & `FSER_SR_MASK;
            n.res = RES_DONE;
            n.st  = S_IDLE;
          end
        end
      end
      S_EVAL: begin
        n.res  = cls;
        n.flg  = flg;
        n.st   = S_IDLE;
        n.step = 3'h0;
        if (s.auto_clr && cls == RES_EMBERR) begin
          n.op = OP_SRCLR;
          n.st = S_SEQ;
        end else if (s.auto_clr && cls == RES_ABORT) begin
          n.op = OP_ABRST;
          n.st = S_SEQ;
        end
      end
      S_WRDY: begin
        // The flash may stay busy for a while after the clear; give up after a bound.
        if (cyc.ry) begin
          n.res = RES_CLEARED;
          n.st  = S_IDLE;
        end else if (s.cnt == 16'(`FSER_RDY_CYC)) begin
          n.res = RES_TIMEOUT;
          n.st  = S_IDLE;
        end else begin
          n.cnt = s.cnt + 16'h0001;
        end
      end
      default: n.st = S_IDLE;
    endcase
    if (RST) begin
      n     = '0;
      n.wrq = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    s <= n;
  end

  assign cyc.req         = s.req;
  assign cyc.we          = s.we;
  assign cyc.addr        = s.ca;
  assign cyc.wdata       = s.cd;
  assign AVS_READDATA    = s.rdat;
  assign AVS_WAITREQUEST = s.wrq;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  AST_POLL_ADDR: assert property (
    (s.req && !s.we && (s.st == S_RD1 || s.st == S_RD2)) |-> (s.ca == s.addr)
  ) else $error("Polling read not at the operation address.");

  AST_ABORT_CLEAR: assert property (
    (s.st == S_EVAL && s.auto_clr && cls == RES_ABORT)
      |=> (s.st == S_SEQ && s.op == OP_ABRST) ##1 (s.req && s.we && s.cd == `FSER_CMD_UNLK1)
  ) else $error("Buffer abort not followed by the abort reset sequence.");

  AST_ERR_CLEAR: assert property (
    (s.st == S_EVAL && s.auto_clr && cls == RES_EMBERR)
      |=> s.op == OP_SRCLR ##1 (s.req && s.we && s.cd == `FSER_CMD_SRCLR)
  ) else $error("Embedded error not followed by a status clear command.");

  AST_MASK_RSV: assert property (
    $rose(s.st == S_EVAL) |-> ((s.p1 | s.p2) & ~`FSER_POLL_MASK) == 16'h0000
  ) else $error("Reserved polling bits not masked.");

  AST_READY_DONE: assert property (
    (s.st == S_WRDY && cyc.ry) |=> (s.st == S_IDLE && s.res == RES_CLEARED)
  ) else $error("Ready after clear not reported.");

  AST_SR_ADDR: assert property (
    (s.req && !s.we && s.st == S_SRD)
      |-> (s.ca == s.addr)
  ) else $error("Status register read not at the operation address.");

  AST_CLEAR_CMD: assert property (
    (s.req && s.st == S_SEQ && s.op == OP_SRCLR)
      |-> (s.we && s.ca == `FSER_A_UNLK1 && s.cd == `FSER_CMD_SRCLR)
  ) else $error("Status clear command malformed.");

  AST_RESET_CMD: assert property (
    (s.req && s.st == S_SEQ && s.op == OP_RESET)
      |-> (s.we && s.ca == `FSER_A_UNLK1 && s.cd == `FSER_CMD_RESET)
  ) else $error("Reset command malformed.");

  AST_ABORT_SEQ: assert property (
    (s.req && s.st == S_SEQ && s.op == OP_ABRST && s.step == 3'h1)
      |-> (s.we && s.ca == `FSER_A_UNLK2 && s.cd == `FSER_CMD_UNLK2)
  ) else $error("Second abort reset cycle malformed.");

  AST_ABORT_END: assert property (
    (s.req && s.st == S_SEQ && s.op == OP_ABRST && s.step == 3'h2)
      |-> (s.we && s.ca == `FSER_A_UNLK1 && s.cd == `FSER_CMD_RESET)
  ) else $error("Last abort reset cycle malformed.");

  AST_ERR_WAIT: assert property (
    (s.st == S_SEQ && s.op == OP_SRCLR && s.pend && cyc.done)
      |=> (s.st == S_WRDY && s.cnt == 16'h0000)
  ) else $error("Status clear not followed by the ready wait.");

  AST_GIVE_UP: assert property (
    (s.st == S_WRDY && !cyc.ry && s.cnt == 16'(`FSER_RDY_CYC))
      |=> (s.st == S_IDLE && s.res == RES_TIMEOUT)
  ) else $error("Ready wait did not end at its bound.");

  AST_AUTO_IDLE: assert property (
    (s.st == S_EVAL && !s.auto_clr)
      |=> (s.st == S_IDLE)
  ) else $error("Poll without automatic clear did not return to idle.");

  // ==========================================================================
  // Coverage
  COV_POLL_DONE: cover property (s.st == S_EVAL && cls == RES_DONE);
  COV_ABORT:     cover property (s.st == S_EVAL && cls == RES_ABORT && s.auto_clr);
  COV_EMBERR:    cover property (s.st == S_EVAL && cls == RES_EMBERR && s.auto_clr);
  COV_CLEARED:   cover property (s.st == S_WRDY ##1 s.res == RES_CLEARED);
  COV_TIMEOUT:   cover property (s.st == S_WRDY ##1 s.res == RES_TIMEOUT);
endmodule

//--- verilog/fser_pin_engine.sv
// Drives one asynchronous read or write cycle on the flash pins.
`timescale 1ns/1ps
`include "fser_defines.svh"
module fser_pin_engine (
  input  wire logic                MCLK,
  input  wire logic                RST,
  fser_cyc_if.phy                  cyc,
  output logic [`FSER_AW-1:0]      fl_a,
  input  wire logic [`FSER_DW-1:0] fl_dq_i,
  output logic [`FSER_DW-1:0]      fl_dq_o,
  output logic                     fl_dq_oe_n,
  output logic                     fl_ce_n,
  output logic                     fl_oe_n,
  output logic                     fl_we_n,
  input  wire logic                fl_ry
);
  import fser_pkg::*;
  typedef struct packed {
    fser_pst_t           st;
    logic [7:0]          cnt;
    logic                wr;
    logic [`FSER_AW-1:0] a;
    logic [`FSER_DW-1:0] dout;
    logic                doe_n;
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic [`FSER_DW-1:0] rdata;
    logic                done;
    logic [`FSER_DW-1:0] dq1;
    logic [`FSER_DW-1:0] dq2;
    logic                ry1;
    logic                ry2;
  } fser_phy_t;
  fser_phy_t s;
  fser_phy_t n;
  always_comb begin
    n      = s;
    n.done = 1'b0;
    n.dq1  = fl_dq_i;
    n.dq2  = s.dq1;
    n.ry1  = fl_ry;
    n.ry2  = s.ry1;
    unique case (s.st)
      P_IDLE: begin
        if (cyc.req) begin
          n.a    = cyc.addr;
          n.wr   = cyc.we;
          n.ce_n = 1'b0;
          n.st   = P_ACT;
          if (cyc.we) begin
            n.we_n  = 1'b0;
            n.dout  = cyc.wdata;
            n.doe_n = 1'b0;
            n.cnt   = 8'(`FSER_WP_CYC);
          end else begin
            n.oe_n = 1'b0;
            n.cnt  = 8'(`FSER_ACC_CYC);
          end
        end
      end
      P_ACT: begin
        if (s.cnt == 8'h01) begin
          // Read data has passed the two-stage synchroniser, hence the longer access count.
          if (!s.wr) begin
            n.rdata = s.dq2;
          end
          n.ce_n = 1'b1;
          n.oe_n = 1'b1;
          n.we_n = 1'b1;
          n.cnt  = 8'(`FSER_REC_CYC);
          n.st   = P_REC;
        end else begin
          n.cnt = s.cnt - 8'h01;
        end
      end
      P_REC: begin
        if (s.cnt == 8'h01) begin
          n.doe_n = 1'b1;
          n.done  = 1'b1;
          n.st    = P_IDLE;
        end else begin
          n.cnt = s.cnt - 8'h01;
        end
      end
      default: n.st = P_IDLE;
    endcase
    if (RST) begin
      n      = '0;
      n.doe_n = 1'b1;
      n.ce_n = 1'b1;
      n.oe_n = 1'b1;
      n.we_n = 1'b1;
    end
  end
  always_ff @(posedge MCLK) begin
    s <= n;
  end
  assign cyc.done   = s.done;
  assign cyc.rdata  = s.rdata;
  assign cyc.ry     = s.ry2;
  assign fl_a       = s.a;
  assign fl_dq_o    = s.dout;
  assign fl_dq_oe_n = s.doe_n;
  assign fl_ce_n    = s.ce_n;
  assign fl_oe_n    = s.oe_n;
  assign fl_we_n    = s.we_n;
endmodule

//--- verilog/fser_pkg.sv
// Types shared by the flash status error reporter host controller.
`include "fser_defines.svh"
package fser_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_SEQ = 3'b001, S_RD1 = 3'b010, S_RD2 = 3'b011,
    S_EVAL = 3'b100, S_SRD = 3'b101, S_WRDY = 3'b110
  } fser_st_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_POLL = 3'b001, OP_SRRD = 3'b010, OP_SRCLR = 3'b011,
    OP_RESET = 3'b100, OP_ABRST = 3'b101
  } fser_op_t;
  typedef enum logic [2:0] {
    RES_NONE = 3'b000, RES_DONE = 3'b001, RES_BUSY = 3'b010, RES_EMBERR = 3'b011,
    RES_ABORT = 3'b100, RES_CLEARED = 3'b101, RES_TIMEOUT = 3'b110
  } fser_res_t;
  typedef enum logic [1:0] {P_IDLE = 2'b00, P_ACT = 2'b01, P_REC = 2'b10} fser_pst_t;
  typedef struct packed {
    logic                 last;
    logic [`FSER_AW-1:0]  a;
    logic [`FSER_DW-1:0]  d;
  } fser_cmd_t;
endpackage

//--- verilog/fser_poll_decode.sv
// Classifies two successive polling reads of the flash.
`timescale 1ns/1ps
`include "fser_defines.svh"
module fser_poll_decode (
  input  wire logic [`FSER_DW-1:0] first,
  input  wire logic [`FSER_DW-1:0] second,
  output fser_pkg::fser_res_t      cls,
  output logic [4:0]               flg
);
  import fser_pkg::*;
  logic tog;
  logic stog;
  always_comb begin
    tog  = first[`FSER_B_GTOG] ^ second[`FSER_B_GTOG];
    stog = first[`FSER_B_STOG] ^ second[`FSER_B_STOG];
    flg  = {second[`FSER_B_ESTART], second[`FSER_B_ABORT], second[`FSER_B_TLIM], stog, tog};
    // The timing flag must be high on both reads; a single high read may race completion.
    if (!tog) begin
      cls = RES_DONE;
    end else if (second[`FSER_B_ABORT]) begin
      cls = RES_ABORT;
    end else if (first[`FSER_B_TLIM] && second[`FSER_B_TLIM]) begin
      cls = RES_EMBERR;
    end else begin
      cls = RES_BUSY;
    end
  end
endmodule
